// *** pcsw_top.sv ***
`timescale 1ns/1ps
`include "pcsw_params.svh"

module pcsw_top (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // Indirect word access from the host port
    input  wire logic [8:0]  host_addr_i,
    input  wire logic [15:0] host_wdata_i,
    input  wire logic        host_wr_i,
    input  wire logic        host_rd_i,
    output logic      [15:0] host_rdata_o,
    // Operating mode selection
    input  wire logic [7:0]  mode_i,
    input  wire logic        mode_wr_i,
    // Pump datapath status
    input  wire logic        baud_tick_i,
    input  wire logic [15:0] line_energy_i,
    input  wire logic [15:0] eye_quality_level_i,
    input  wire logic        link_up_i,
    input  wire logic        retrain_done_i,
    // Pump datapath controls
    output logic             guard_tone_en_o,
    output logic      [10:0] guard_tone_hz_o,
    output logic             equalizer_hold_o,
    output logic             equalizer_clear_o,
    output logic             half_spaced_o,
    output logic             retrain_start_o,
    output logic             carrier_present_o,
    output logic             eye_quality_alarm_o,
    output logic             line_relay_n_o
);

    // V.22 family modes
    function automatic logic is_v22_family(input logic [7:0] m);
        is_v22_family = (m == `PCSW_MODE_V22BIS) || (m == `PCSW_MODE_V22) ||
                        (m == `PCSW_MODE_V22_ALT);
    endfunction : is_v22_family

    // Any data mode
    function automatic logic is_data_mode(input logic [7:0] m);
        is_data_mode = is_v22_family(m) || (m == `PCSW_MODE_V21) ||
                       (m == `PCSW_MODE_FSK_ALT) ||
                       (m == `PCSW_MODE_V23_FWD) ||
                       (m == `PCSW_MODE_V23_REV);
    endfunction : is_data_mode

    // Host write strobe for one offset
    function automatic logic wr_hit(input logic [8:0] ofs);
        wr_hit = host_wr_i && (host_addr_i == ofs);
    endfunction : wr_hit

    pcsw_pkg::pcsw_word_t  carrier_on_level;
    pcsw_pkg::pcsw_word_t  carrier_off_level;
    pcsw_pkg::pcsw_word_t  eye_quality_limit;
    pcsw_pkg::pcsw_word_t  line_control_status;
    pcsw_pkg::pcsw_word_t  pump_misc_control;
    pcsw_pkg::pcsw_word_t  on_level_act;
    pcsw_pkg::pcsw_word_t  off_level_act;
    pcsw_pkg::pcsw_word_t  eye_limit_act;
    pcsw_pkg::pcsw_train_e train_state;
    logic [7:0]            mode;
    logic                  carrier_present;
    logic                  mode_change;
    logic                  data_sel;
    logic                  start_train;
    logic                  eye_over;

    // Mode write decode
    assign mode_change = mode_wr_i && (mode_i != mode);
    assign data_sel    = mode_wr_i && is_data_mode(mode_i);

    // Retrain allowed only on an established V.22bis link
    assign start_train = line_control_status[`PCSW_BIT_RETRAIN] &&
                         (mode == `PCSW_MODE_V22BIS) && link_up_i &&
                         (train_state == pcsw_pkg::PCSW_IDLE);

    // Eye quality over limit in V.22 family data
    assign eye_over = is_v22_family(mode) &&
                      (eye_quality_level_i > eye_limit_act);

    // Current operating mode
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode <= `PCSW_MODE_STANDBY;
        end else if (mode_wr_i) begin
            mode <= mode_i;
        end
    end

    // Threshold words as written by the host
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            carrier_on_level  <= `PCSW_RST_CARRIER_ON;
            carrier_off_level <= `PCSW_RST_CARRIER_OFF;
            eye_quality_limit <= `PCSW_RST_EYE_LIMIT;
        end else begin
            if (wr_hit(`PCSW_OFS_CARRIER_ON)) begin
                carrier_on_level <= host_wdata_i;
            end
            if (wr_hit(`PCSW_OFS_CARRIER_OFF)) begin
                carrier_off_level <= host_wdata_i;
            end
            if (wr_hit(`PCSW_OFS_EYE_LIMIT)) begin
                eye_quality_limit <= host_wdata_i;
            end
        end
    end

    // Working copies, loaded at the end of each baud period
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            on_level_act  <= `PCSW_RST_CARRIER_ON;
            off_level_act <= `PCSW_RST_CARRIER_OFF;
            eye_limit_act <= `PCSW_RST_EYE_LIMIT;
        end else if (baud_tick_i) begin
            on_level_act  <= carrier_on_level;
            off_level_act <= carrier_off_level;
            eye_limit_act <= eye_quality_limit;
        end
    end

    // Miscellaneous control word; alarm set beats host clear
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pump_misc_control <= `PCSW_RST_MISC_CTL;
        end else begin
            if (wr_hit(`PCSW_OFS_MISC_CTL)) begin
                pump_misc_control <= host_wdata_i & `PCSW_MISC_WR_MASK;
            end
            if (eye_over) begin
                pump_misc_control[`PCSW_BIT_EYE_ALARM] <= 1'b1;
            end
        end
    end

    // Line control word: retrain and line seize bits
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            line_control_status <= `PCSW_RST_LINE_CTL;
        end else begin
            if (wr_hit(`PCSW_OFS_LINE_CTL)) begin
                line_control_status <= host_wdata_i & `PCSW_LINE_WR_MASK;
            end
            if (start_train || data_sel) begin
                line_control_status[`PCSW_BIT_RETRAIN] <= 1'b0;
            end
            if (data_sel || (mode_wr_i && mode_i == `PCSW_MODE_DIAL)) begin
                line_control_status[`PCSW_BIT_LINE_SEIZE] <= 1'b1;
            end
        end
    end

    // Retrain sequencing
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            train_state <= pcsw_pkg::PCSW_IDLE;
        end else begin
            case (train_state)
                pcsw_pkg::PCSW_IDLE: begin
                    if (start_train) begin
                        train_state <= pcsw_pkg::PCSW_TRAIN;
                    end
                end
                pcsw_pkg::PCSW_TRAIN: begin
                    if (retrain_done_i || mode_wr_i) begin
                        train_state <= pcsw_pkg::PCSW_IDLE;
                    end
                end
                default: begin
                    train_state <= pcsw_pkg::PCSW_IDLE;
                end
            endcase
        end
    end

    // Carrier flag with hysteresis and retrain override
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            carrier_present <= 1'b0;
        end else if (start_train) begin
            carrier_present <= 1'b0;
        end else if (train_state == pcsw_pkg::PCSW_TRAIN) begin
            if (retrain_done_i) begin
                carrier_present <= 1'b1;
            end
        end else if (carrier_present) begin
            if (line_energy_i < off_level_act) begin
                carrier_present <= 1'b0;
            end
        end else if (line_energy_i > on_level_act) begin
            carrier_present <= 1'b1;
        end
    end

    // Registered one-cycle pulses toward the datapath
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            equalizer_clear_o <= 1'b0;
            retrain_start_o   <= 1'b0;
        end else begin
            equalizer_clear_o <= mode_change;
            retrain_start_o   <= start_train;
        end
    end

    // Host read data, one cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            host_rdata_o <= 16'h0000;
        end else if (host_rd_i) begin
            case (host_addr_i)
                `PCSW_OFS_CARRIER_ON:  host_rdata_o <= carrier_on_level;
                `PCSW_OFS_CARRIER_OFF: host_rdata_o <= carrier_off_level;
                `PCSW_OFS_EYE_LIMIT:   host_rdata_o <= eye_quality_limit;
                `PCSW_OFS_LINE_CTL:    host_rdata_o <= line_control_status;
                `PCSW_OFS_MISC_CTL:    host_rdata_o <= pump_misc_control;
                default:               host_rdata_o <= 16'h0000;
            endcase
        end
    end

    // Datapath control outputs
    assign guard_tone_en_o = pump_misc_control[`PCSW_BIT_GUARD_ON] &&
                             is_v22_family(mode);
    assign guard_tone_hz_o = pump_misc_control[`PCSW_BIT_GUARD_PICK] ?
                             `PCSW_GUARD_HIGH_HZ :
                             `PCSW_GUARD_LOW_HZ;
    assign equalizer_hold_o = pump_misc_control[`PCSW_BIT_EQ_HOLD];
    assign half_spaced_o   = !pump_misc_control[`PCSW_BIT_EQ_SPACING] ||
                             is_v22_family(mode);
    assign carrier_present_o   = carrier_present;
    assign eye_quality_alarm_o = pump_misc_control[`PCSW_BIT_EYE_ALARM];
    assign line_relay_n_o = ~line_control_status[`PCSW_BIT_LINE_SEIZE];

    // Checks
    a_guard_tone_gate: assert property (
        @(posedge clock_i) disable iff (rst_i)
        guard_tone_en_o |-> (pump_misc_control[`PCSW_BIT_GUARD_ON] &&
                             is_v22_family(mode)))
        else $error("guard tone on outside V.22 family or while disabled");

    a_guard_tone_freq: assert property (
        @(posedge clock_i) disable iff (rst_i)
        guard_tone_hz_o == (pump_misc_control[`PCSW_BIT_GUARD_PICK] ?
                            11'd1800 : 11'd550))
        else $error("guard tone frequency mismatch");

    a_eye_alarm_set: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (is_v22_family(mode) && eye_quality_level_i > eye_limit_act)
        |=> eye_quality_alarm_o)
        else $error("eye alarm not raised on excess level");

    a_eye_limit_load: assert property (
        @(posedge clock_i) disable iff (rst_i)
        baud_tick_i |=> eye_limit_act == $past(eye_quality_limit))
        else $error("eye limit not loaded at baud end");

    a_eq_hold_follow: assert property (
        @(posedge clock_i) disable iff (rst_i)
        equalizer_hold_o == pump_misc_control[3])
        else $error("equalizer hold does not track its bit");

    a_eq_clear_mode: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (mode_wr_i && mode_i != mode) |=> equalizer_clear_o)
        else $error("no coefficient clear after mode change");

    a_half_spacing: assert property (
        @(posedge clock_i) disable iff (rst_i)
        is_v22_family(mode) |-> half_spaced_o)
        else $error("V.22 family not half-spaced");

    a_retrain_only_v22bis: assert property (
        @(posedge clock_i) disable iff (rst_i)
        $rose(retrain_start_o) |-> $past(mode == 8'h08 && link_up_i))
        else $error("retrain started without V.22bis link");

    a_carrier_retrain: assert property (
        @(posedge clock_i) disable iff (rst_i)
        start_train |=> !carrier_present_o &&
                        train_state == pcsw_pkg::PCSW_TRAIN)
        else $error("carrier flag not dropped at retrain start");

    a_carrier_restore: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (train_state == pcsw_pkg::PCSW_TRAIN && retrain_done_i && !mode_wr_i)
        |=> carrier_present_o && train_state == pcsw_pkg::PCSW_IDLE)
        else $error("carrier flag not restored after retrain");

    a_retrain_clear: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (start_train || data_sel) |=> !line_control_status[11])
        else $error("retrain bit not self-cleared");

    a_relay_inverse: assert property (
        @(posedge clock_i) disable iff (rst_i)
        line_relay_n_o != line_control_status[2])
        else $error("relay pin not inverse of seize bit");

    a_seize_on_mode: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (mode_wr_i && (mode_i == 8'h03 || is_data_mode(mode_i)))
        |=> !line_relay_n_o)
        else $error("line not seized on dial or data mode");

    a_carrier_off: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (carrier_present && train_state == pcsw_pkg::PCSW_IDLE &&
         line_energy_i < off_level_act) |=> !carrier_present_o)
        else $error("carrier flag kept below off threshold");

    a_carrier_on: assert property (
        @(posedge clock_i) disable iff (rst_i)
        (!carrier_present && !start_train &&
         train_state == pcsw_pkg::PCSW_IDLE &&
         line_energy_i > on_level_act) |=> carrier_present_o)
        else $error("carrier flag not set above on threshold");

    a_threshold_hold: assert property (
        @(posedge clock_i) disable iff (rst_i)
        !baud_tick_i |=> $stable(on_level_act) && $stable(off_level_act))
        else $error("threshold changed between baud ends");

    a_reset_values: assert property (
        @(posedge clock_i)
        $past(rst_i) |-> (line_control_status == 16'h0000 &&
                          carrier_on_level == 16'h00e8 &&
                          carrier_off_level == 16'h0082 &&
                          eye_quality_limit == 16'h0400))
        else $error("reset values not restored");

endmodule : pcsw_top

// *** pcsw_params.svh ***
`ifndef PCSW_PARAMS_SVH
`define PCSW_PARAMS_SVH

// Word offsets in pump RAM
`define PCSW_OFS_CARRIER_ON   9'h1f4
`define PCSW_OFS_CARRIER_OFF  9'h1f5
`define PCSW_OFS_EYE_LIMIT    9'h1f6
`define PCSW_OFS_LINE_CTL     9'h1f7
`define PCSW_OFS_MISC_CTL     9'h1f8

// Reset values; thresholds are 32767*10^(dBm/20)
`define PCSW_RST_CARRIER_ON   16'h00e8
`define PCSW_RST_CARRIER_OFF  16'h0082
`define PCSW_RST_EYE_LIMIT    16'h0400
`define PCSW_RST_LINE_CTL     16'h0000
`define PCSW_RST_MISC_CTL     16'h0000

// Miscellaneous control word fields
`define PCSW_BIT_GUARD_ON     9
`define PCSW_BIT_GUARD_PICK   8
`define PCSW_BIT_EYE_ALARM    4
`define PCSW_BIT_EQ_HOLD      3
`define PCSW_BIT_EQ_SPACING   2
`define PCSW_MISC_WR_MASK     16'hcf1c

// Line control and status word fields
`define PCSW_BIT_RETRAIN      11
`define PCSW_BIT_LINE_SEIZE   2
`define PCSW_LINE_WR_MASK     16'h0804

// Operating mode codes
`define PCSW_MODE_STANDBY     8'h00
`define PCSW_MODE_DIAL        8'h03
`define PCSW_MODE_V22BIS      8'h08
`define PCSW_MODE_V22         8'h09
`define PCSW_MODE_V22_ALT     8'h0b
`define PCSW_MODE_V21         8'h10
`define PCSW_MODE_FSK_ALT     8'h11
`define PCSW_MODE_V23_FWD     8'h13
`define PCSW_MODE_V23_REV     8'h14

// Guard tone frequencies in Hz
`define PCSW_GUARD_LOW_HZ     11'd550
`define PCSW_GUARD_HIGH_HZ    11'd1800

`endif

// *** pcsw_pkg.sv ***
package pcsw_pkg;

    typedef logic [15:0] pcsw_word_t;

    // Retrain sequencing
    typedef enum logic [0:0] {
        PCSW_IDLE  = 1'b0,
        PCSW_TRAIN = 1'b1
    } pcsw_train_e;

endpackage : pcsw_pkg

// *** pcsw_host_model.sv ***
`timescale 1ns/1ps
// Host processor side: indirect word port and mode select
module pcsw_host_model (
    // Clock
    input  wire logic        clock_i,
    // Word port towards the pump
    output logic      [8:0]  host_addr_o,
    output logic      [15:0] host_wdata_o,
    output logic             host_wr_o,
    output logic             host_rd_o,
    input  wire logic [15:0] host_rdata_i,
    // Mode select towards the pump
    output logic      [7:0]  mode_o,
    output logic             mode_wr_o
);
    // Quiet bus at time zero
    initial begin
        host_addr_o  = 9'h000;
        host_wdata_o = 16'h0000;
        host_wr_o    = 1'b0;
        host_rd_o    = 1'b0;
        mode_o       = 8'h00;
        mode_wr_o    = 1'b0;
    end

    // One word access; released address and data lines show inverted values, strobes drop to 0
    task automatic access(input logic wr, input logic [8:0] a,
                          input logic [15:0] d, output logic [15:0] q);
        host_addr_o  <= a;
        host_wdata_o <= d;
        host_wr_o    <= wr;
        host_rd_o    <= ~wr;
        @(posedge clock_i);
        host_wr_o    <= 1'b0;
        host_rd_o    <= 1'b0;
        host_addr_o  <= ~a;
        host_wdata_o <= ~d;
        @(posedge clock_i);
        q = host_rdata_i;
    endtask : access

    // Mode pulse; only the mode-code loop sets guard bits first, never misc in retrain
    task automatic select_mode(input logic [7:0] m);
        mode_o    <= m;
        mode_wr_o <= 1'b1;
        @(posedge clock_i);
        mode_wr_o <= 1'b0;
        mode_o    <= ~m;
        @(posedge clock_i);
    endtask : select_mode
endmodule : pcsw_host_model

// *** testbench.sv ***
`timescale 1ns/1ps
`include "pcsw_params.svh"
module testbench;
    logic        clock_i, rst_i, host_wr_i, host_rd_i, mode_wr_i;
    logic        baud_tick_i, link_up_i, retrain_done_i;
    logic [8:0]  host_addr_i;
    logic [7:0]  mode_i;
    logic [15:0] host_wdata_i, host_rdata_o, q, d;
    logic [15:0] line_energy_i, eye_quality_level_i;
    logic [10:0] guard_tone_hz_o;
    logic        guard_tone_en_o, equalizer_hold_o, equalizer_clear_o;
    logic        half_spaced_o, retrain_start_o, carrier_present_o;
    logic        eye_quality_alarm_o, line_relay_n_o;
    int          bad_count = 0;
    int          checks = 0;
    int          clear_cnt = 0;
    int          start_cnt = 0;
    int          n;
    logic [7:0]  modes [9] = '{`PCSW_MODE_STANDBY, `PCSW_MODE_DIAL,
        `PCSW_MODE_V22BIS, `PCSW_MODE_V22, `PCSW_MODE_V22_ALT,
        `PCSW_MODE_V21, `PCSW_MODE_FSK_ALT, `PCSW_MODE_V23_FWD,
        `PCSW_MODE_V23_REV};

    pcsw_top uut (.*);

    pcsw_host_model host (
        .clock_i      (clock_i),
        .host_addr_o  (host_addr_i),
        .host_wdata_o (host_wdata_i),
        .host_wr_o    (host_wr_i),
        .host_rd_o    (host_rd_i),
        .host_rdata_i (host_rdata_o),
        .mode_o       (mode_i),
        .mode_wr_o    (mode_wr_i)
    );

    // 200 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // Pulse counters, sampled mid-cycle
    always @(negedge clock_i) begin
        if (equalizer_clear_o === 1'b1) clear_cnt++;
        if (retrain_start_o === 1'b1) start_cnt++;
    end

    function automatic logic is_v22(input logic [7:0] m);
        return m == `PCSW_MODE_V22BIS || m == `PCSW_MODE_V22 ||
               m == `PCSW_MODE_V22_ALT;
    endfunction : is_v22

    function automatic logic [15:0] hz(input logic pick);
        return pick ? 16'd1800 : 16'd550;
    endfunction : hz

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [8:0] a, input logic [15:0] v);
        host.access(1'b1, a, v, q);
    endtask : wr

    task automatic rd_check(input logic [8:0] a, input logic [15:0] e);
        host.access(1'b0, a, 16'h0000, q);
        check(q, e);
    endtask : rd_check

    // Drive eye level or line energy, then compare alarm or carrier
    task automatic stim(input logic eye, input logic [15:0] v,
                        input logic e);
        if (eye) eye_quality_level_i <= v;
        else line_energy_i <= v;
        repeat (2) @(posedge clock_i);
        check(eye ? eye_quality_alarm_o : carrier_present_o, 16'(e));
    endtask : stim

    task automatic tick_baud;
        baud_tick_i <= 1'b1;
        @(posedge clock_i);
        baud_tick_i <= 1'b0;
        @(posedge clock_i);
    endtask : tick_baud

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        void'($urandom(35));
        rst_i = 1'b1;
        baud_tick_i = 1'b0;
        link_up_i = 1'b0;
        retrain_done_i = 1'b0;
        line_energy_i = 16'h0000;
        eye_quality_level_i = 16'h0000;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check(line_relay_n_o, 16'h0001);
        rd_check(`PCSW_OFS_CARRIER_ON, 16'h00e8);
        rd_check(`PCSW_OFS_CARRIER_OFF, 16'h0082);
        rd_check(`PCSW_OFS_EYE_LIMIT, 16'h0400);
        rd_check(`PCSW_OFS_LINE_CTL, 16'h0000);
        rd_check(`PCSW_OFS_MISC_CTL, 16'h0000);
        rd_check(9'h1f9, 16'h0000);
        // Random words in standby; guard bit kept off here
        repeat (6) begin
            d = 16'($urandom);
            wr(`PCSW_OFS_LINE_CTL, d);
            rd_check(`PCSW_OFS_LINE_CTL, d & 16'h0804);
            check(line_relay_n_o, {15'h0, ~d[2]});
            d = 16'($urandom) & 16'hfdff;
            wr(`PCSW_OFS_MISC_CTL, d);
            rd_check(`PCSW_OFS_MISC_CTL, d & 16'hcf1c);
            check(equalizer_hold_o, {15'h0, d[3]});
            check(16'(guard_tone_hz_o), hz(d[8]));
            check(half_spaced_o, {15'h0, ~d[2]});
        end
        // Every mode code, guard bits written before the mode
        foreach (modes[i]) begin
            host.select_mode(`PCSW_MODE_STANDBY);
            wr(`PCSW_OFS_LINE_CTL, 16'h0000);
            d = {6'h00, is_v22(modes[i]), 1'($urandom), 8'h04};
            wr(`PCSW_OFS_MISC_CTL, d);
            n = clear_cnt;
            host.select_mode(modes[i]);
            check(16'(clear_cnt - n), 16'(modes[i] != 8'h00));
            check(line_relay_n_o, 16'(modes[i] == 8'h00));
            check(guard_tone_en_o, 16'(is_v22(modes[i])));
            check(half_spaced_o, 16'(is_v22(modes[i])));
            check(16'(guard_tone_hz_o), hz(d[8]));
            rd_check(`PCSW_OFS_LINE_CTL, {13'h0, modes[i] != 8'h00,
                     2'h0});
        end
        // Carrier hysteresis and delayed threshold update
        host.select_mode(`PCSW_MODE_STANDBY);
        wr(`PCSW_OFS_MISC_CTL, 16'h0000);
        stim(1'b0, 16'h00e8, 1'b0);
        stim(1'b0, 16'h0100 | 16'($urandom & 16'h7fff), 1'b1);
        stim(1'b0, 16'h0082, 1'b1);
        stim(1'b0, 16'h0081, 1'b0);
        stim(1'b0, 16'h00a0, 1'b0);
        wr(`PCSW_OFS_CARRIER_ON, 16'h1000);
        stim(1'b0, 16'h0800, 1'b1);
        stim(1'b0, 16'h0010, 1'b0);
        tick_baud();
        stim(1'b0, 16'h0800, 1'b0);
        stim(1'b0, 16'h1001, 1'b1);
        // Eye alarm: sticky, limit change waits for a baud tick
        host.select_mode(`PCSW_MODE_V22);
        stim(1'b1, 16'h0400, 1'b0);
        stim(1'b1, 16'h0401, 1'b1);
        stim(1'b1, 16'h0000, 1'b1);
        wr(`PCSW_OFS_MISC_CTL, 16'h0000);
        wr(`PCSW_OFS_EYE_LIMIT, 16'h2000);
        stim(1'b1, 16'h1000, 1'b1);
        stim(1'b1, 16'h0000, 1'b1);
        wr(`PCSW_OFS_MISC_CTL, 16'h0000);
        tick_baud();
        stim(1'b1, 16'h1000, 1'b0);
        stim(1'b1, 16'h2001, 1'b1);
        stim(1'b1, 16'h0000, 1'b1);
        wr(`PCSW_OFS_MISC_CTL, 16'h0000);
        host.select_mode(`PCSW_MODE_V21);
        stim(1'b1, 16'hffff, 1'b0);
        eye_quality_level_i <= 16'h0000;
        // Retrain only on V.22bis with the link up
        link_up_i <= 1'b1;
        host.select_mode(`PCSW_MODE_V22);
        n = start_cnt;
        wr(`PCSW_OFS_LINE_CTL, 16'h0804);
        rd_check(`PCSW_OFS_LINE_CTL, 16'h0804);
        host.select_mode(`PCSW_MODE_V22BIS);
        rd_check(`PCSW_OFS_LINE_CTL, 16'h0004);
        check(16'(start_cnt - n), 16'h0000);
        stim(1'b0, 16'h4000, 1'b1);
        wr(`PCSW_OFS_LINE_CTL, 16'h0804);
        @(posedge clock_i);
        check(16'(start_cnt - n), 16'h0001);
        check(carrier_present_o, 16'h0000);
        rd_check(`PCSW_OFS_LINE_CTL, 16'h0004);
        retrain_done_i <= 1'b1;
        @(posedge clock_i);
        retrain_done_i <= 1'b0;
        @(posedge clock_i);
        check(carrier_present_o, 16'h0001);
        // Reset in mid-run restores defaults
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check(line_relay_n_o, 16'h0001);
        check(carrier_present_o, 16'h0000);
        rd_check(`PCSW_OFS_EYE_LIMIT, 16'h0400);
        rd_check(`PCSW_OFS_CARRIER_ON, 16'h00e8);
        rd_check(`PCSW_OFS_LINE_CTL, 16'h0000);
        report_and_stop();
    end
endmodule : testbench
